// file: hdl/kbi_pkg.sv
// kbi_pkg: constants shared by the keyboard level interrupt block
// assumes an 8-bit special function register bus with 8-bit addresses
package kbi_pkg;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int          KBI_LINES      = 8;
  localparam int          KBI_SYNC_DEPTH = 2;

  // ------------------------------------------------------------------
  // register offsets on the sfr bus
  // ------------------------------------------------------------------
  localparam logic [7:0]  KBI_LEVEL_SELECT_ADDR = 8'h9c;
  localparam logic [7:0]  KBI_LINE_ENABLE_ADDR  = 8'h9d;
  localparam logic [7:0]  KBI_LINE_FLAGS_ADDR   = 8'h9e;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0]  KBI_LEVEL_SELECT_RST  = 8'h00;
  localparam logic [7:0]  KBI_LINE_ENABLE_RST   = 8'h00;
  localparam logic [7:0]  KBI_LINE_FLAGS_RST    = 8'h00;
  localparam logic [7:0]  KBI_RDATA_RST         = 8'h00;
  // synchroniser starts at the pulled-up idle level of the pins
  localparam logic [7:0]  KBI_SYNC_RST          = 8'hff;

endpackage : kbi_pkg

// file: hdl/kbi_sync.sv
// kbi_sync: two-stage synchroniser for the port one keyboard inputs
// assumes the pins are asynchronous to sys_clk_in
`timescale 1ns/100ps
module kbi_sync (
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [7:0] async_in,
  output logic      [7:0] sync_out
);

  typedef struct packed {
    logic [7:0] stage_one;
    logic [7:0] stage_two;
  } kbi_sync_state_t;

  kbi_sync_state_t state;
  kbi_sync_state_t next_state;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_state           = state;
    next_state.stage_one = async_in;
    next_state.stage_two = state.stage_one;
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      // a zero here would read as a low level on every line
      state.stage_one <= kbi_pkg::KBI_SYNC_RST;
      state.stage_two <= kbi_pkg::KBI_SYNC_RST;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stage_two;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  AST_SYNC_LATENCY: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    !$past(sys_rst_in, 1) && !$past(sys_rst_in, 2)
      |-> sync_out == $past(async_in, 2))
    else $error("synchroniser latency is not two clocks");

endmodule : kbi_sync

// file: hdl/kbi_line.sv
// kbi_line: level detector and sticky flag for one keyboard line
// assumes its level input is already synchronised to sys_clk_in
`timescale 1ns/100ps
module kbi_line (
  input  wire logic sys_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic level_in,
  input  wire logic level_select_in,
  input  wire logic line_enable_in,
  input  wire logic flag_clear_in,
  output logic      flag_out,
  output logic      hit_out,
  output logic      request_out
);

  typedef struct packed {
    logic flag;
  } kbi_line_state_t;

  kbi_line_state_t state;
  kbi_line_state_t next_state;
  logic            hit;

  // ------------------------------------------------------------------
  // detect and flag
  // ------------------------------------------------------------------
  always_comb begin
    hit             = (level_in == level_select_in);
    next_state      = state;
    // a hit in the clearing cycle keeps the flag set
    next_state.flag = (state.flag & ~flag_clear_in) | hit;
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flag_out    = state.flag;
  assign hit_out     = hit;
  assign request_out = state.flag & line_enable_in;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  AST_LINE_SET_WINS: assert property (
    @(posedge sys_clk_in) disable iff (sys_rst_in)
    hit && flag_clear_in |=> flag_out)
    else $error("flag lost when set and clear coincide");

endmodule : kbi_line

// file: hdl/kbi_top.sv
// kbi_top: keyboard level interrupt on port one, eight lines
// assumes an sfr bus with one-cycle rd/wr strobes and a global enable
// bit held in the interrupt enable register outside this block
`timescale 1ns/100ps
module kbi_top (
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic [7:0] port_one_in,
  input  wire logic       keypad_global_irq_enable_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic      [7:0] sfr_rdata_out,
  output logic      [7:0] key_line_enable_alias_out,
  output logic            key_irq_out,
  output logic            key_wake_out
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] key_level_select;
    logic [7:0] key_line_enable;
    logic [7:0] rdata;
    logic [7:0] enable_alias;
    logic       irq;
    logic       wake;
  } kbi_top_state_t;

  kbi_top_state_t state;
  kbi_top_state_t next_state;

  logic [7:0] level_sync;
  logic [7:0] key_line_flags;
  logic [7:0] line_hit;
  logic [7:0] line_request;
  logic       flags_read;
  logic       sel_wr;
  logic       en_wr;

  // ------------------------------------------------------------------
  // input synchroniser
  // ------------------------------------------------------------------
  kbi_sync u_sync (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (port_one_in),
    .sync_out   (level_sync)
  );

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  assign flags_read = sfr_rd_in
                    && (sfr_addr_in == kbi_pkg::KBI_LINE_FLAGS_ADDR);
  assign sel_wr     = sfr_wr_in
                    && (sfr_addr_in == kbi_pkg::KBI_LEVEL_SELECT_ADDR);
  assign en_wr      = sfr_wr_in
                    && (sfr_addr_in == kbi_pkg::KBI_LINE_ENABLE_ADDR);

  // ------------------------------------------------------------------
  // per-line detectors
  // ------------------------------------------------------------------
  for (genvar i = 0; i < kbi_pkg::KBI_LINES; i++) begin : g_line
    kbi_line u_line (
      .sys_clk_in      (sys_clk_in),
      .sys_rst_in      (sys_rst_in),
      .level_in        (level_sync[i]),
      .level_select_in (state.key_level_select[i]),
      .line_enable_in  (state.key_line_enable[i]),
      .flag_clear_in   (flags_read),
      .flag_out        (key_line_flags[i]),
      .hit_out         (line_hit[i]),
      .request_out     (line_request[i])
    );
  end

  // ------------------------------------------------------------------
  // registers and outputs
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (sel_wr) begin
      next_state.key_level_select = sfr_wdata_in;
    end
    if (en_wr) begin
      next_state.key_line_enable = sfr_wdata_in;
    end
    // flags register ignores writes
    case (sfr_addr_in)
      kbi_pkg::KBI_LEVEL_SELECT_ADDR: begin
        next_state.rdata = state.key_level_select;
      end
      kbi_pkg::KBI_LINE_ENABLE_ADDR: begin
        next_state.rdata = state.key_line_enable;
      end
      kbi_pkg::KBI_LINE_FLAGS_ADDR: begin
        next_state.rdata = key_line_flags;
      end
      default: begin
        next_state.rdata = 8'h00;
      end
    endcase
    if (!sfr_rd_in) begin
      next_state.rdata = state.rdata;
    end
    next_state.enable_alias = state.key_line_enable;
    next_state.irq  = keypad_global_irq_enable_in
                    && (|line_request);
    next_state.wake = |(line_hit & state.key_line_enable);
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state.key_level_select <= kbi_pkg::KBI_LEVEL_SELECT_RST;
      state.key_line_enable  <= kbi_pkg::KBI_LINE_ENABLE_RST;
      state.rdata            <= kbi_pkg::KBI_RDATA_RST;
      state.enable_alias     <= kbi_pkg::KBI_LINE_ENABLE_RST;
      state.irq              <= 1'b0;
      state.wake             <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign sfr_rdata_out             = state.rdata;
  assign key_line_enable_alias_out = state.enable_alias;
  assign key_irq_out               = state.irq;
  assign key_wake_out              = state.wake;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  AST_RESET_ZERO: assert property (
    $fell(sys_rst_in) |-> state.key_level_select == 8'h00
      && state.key_line_enable == 8'h00
      && key_line_flags == 8'h00 && !key_irq_out)
    else $error("registers not zero after reset");

  AST_FLAG_SET: assert property (
    line_hit != 8'h00
      |=> (key_line_flags & $past(line_hit)) == $past(line_hit))
    else $error("flag not set on selected level");

  AST_READ_CLEARS: assert property (
    flags_read |=> key_line_flags == $past(line_hit))
    else $error("flags read did not clear");

  AST_READ_DATA: assert property (
    flags_read |=> sfr_rdata_out == $past(key_line_flags))
    else $error("flags read returned wrong data");

  AST_LEVEL_WRITE: assert property (
    sel_wr |=> state.key_level_select == $past(sfr_wdata_in))
    else $error("level select write lost");

  AST_GLOBAL_GATE: assert property (
    !keypad_global_irq_enable_in |=> !key_irq_out)
    else $error("request with global enable clear");

  AST_MASKED: assert property (
    (key_line_flags & state.key_line_enable) == 8'h00 |=> !key_irq_out)
    else $error("request from a disabled line");

  AST_COMBINED: assert property (
    keypad_global_irq_enable_in
      && (|(key_line_flags & state.key_line_enable)) |=> key_irq_out)
    else $error("enabled flag gave no request");

  AST_WAKE: assert property (
    (|(line_hit & state.key_line_enable)) |=> key_wake_out)
    else $error("enabled detection gave no wake");

  AST_ALIAS: assert property (
    en_wr ##1 !en_wr |=> key_line_enable_alias_out == $past(sfr_wdata_in, 2))
    else $error("enable alias does not follow enable");

  AST_ENABLE_WRITE: assert property (
    en_wr |=> state.key_line_enable == $past(sfr_wdata_in))
    else $error("line enable write lost");

  AST_NO_WAKE: assert property (
    (line_hit & state.key_line_enable) == 8'h00 |=> !key_wake_out)
    else $error("wake without an enabled detection");

  AST_FLAGS_READ_ONLY: assert property (
    1'b1 |=> (key_line_flags & ~$past(key_line_flags)
      & ~$past(line_hit)) == 8'h00)
    else $error("flag set without a detected level");

  AST_LEVEL_READ: assert property (
    sfr_rd_in && sfr_addr_in == kbi_pkg::KBI_LEVEL_SELECT_ADDR
      |=> sfr_rdata_out == $past(state.key_level_select))
    else $error("level select read returned wrong data");

  COV_IRQ:      cover property (flags_read ##1 key_irq_out);
  COV_CLEAR:    cover property ($fell(key_irq_out));
  COV_WAKE:     cover property (!key_wake_out ##1 key_wake_out);
  COV_HIGHLVL:  cover property (sel_wr && sfr_wdata_in == 8'hff);

endmodule : kbi_top

// file: sim/kbi_keypad.sv
// kbi_keypad: keyboard matrix model standing on the port one pins
// assumes pulled-up lines; a pressed key pulls its line low
`timescale 1ns/100ps
module kbi_keypad (
  input  wire logic [7:0] key_down_in,
  output logic      [7:0] pins_out
);
  // --------------------------------------------------------------
  // pins
  // --------------------------------------------------------------
  // any set of lines may carry keys; released lines sit at pull-up
  assign pins_out = ~key_down_in;
endmodule : kbi_keypad

// file: sim/tb_keyboard_level_interrupt.sv
// tb_keyboard_level_interrupt: self-checking bench for kbi_top
// assumes kbi_keypad on the pins and the sfr strobe bus of kbi_top
`timescale 1ns/100ps
module tb_keyboard_level_interrupt;
  logic        sys_clk_in;
  logic        sys_rst_in;
  logic        glob;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  alias_o;
  logic [7:0]  keys;
  logic [7:0]  pins;
  logic [7:0]  q;
  logic        irq;
  logic        wake;
  logic [31:0] seed;
  logic [7:0]  m_sel;
  logic [7:0]  m_en;
  logic [7:0]  m_flags;
  int          error_cnt;
  int          num_checks;

  kbi_keypad pad (.key_down_in(keys), .pins_out(pins));

  kbi_top uut (
    .sys_clk_in                  (sys_clk_in),
    .sys_rst_in                  (sys_rst_in),
    .port_one_in                 (pins),
    .keypad_global_irq_enable_in (glob),
    .sfr_addr_in                 (addr),
    .sfr_wr_in                   (wr),
    .sfr_rd_in                   (rd),
    .sfr_wdata_in                (wdata),
    .sfr_rdata_out               (rdata),
    .key_line_enable_alias_out   (alias_o),
    .key_irq_out                 (irq),
    .key_wake_out                (wake)
  );

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [7:0] hit();
    return ~(pins ^ m_sel);
  endfunction : hit

  task automatic complete_run();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one access: strobe for a single edge, data one edge later
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] r);
    @(negedge sys_clk_in);
    wr    = w;
    rd    = ~w;
    addr  = a;
    wdata = d;
    @(negedge sys_clk_in);
    wr = 1'b0;
    rd = 1'b0;
    @(posedge sys_clk_in);
    #1 r = rdata;
  endtask : bus

  task automatic settle();
    repeat (6) @(posedge sys_clk_in);
    #1 m_flags = m_flags | hit();
  endtask : settle

  // --------------------------------------------------------------
  // clock, watchdog, main sequence
  // --------------------------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  initial begin
    repeat (50000) @(posedge sys_clk_in);
    error_cnt++;
    complete_run();
  end

  initial begin
    sys_rst_in = 1'b1;
    {glob, wr, rd} = 3'h0;
    {addr, wdata, keys} = 24'h000000;
    {m_sel, m_en, m_flags} = 24'h000000;
    seed = 32'h7b7b;
    error_cnt = 0;
    num_checks = 0;
    repeat (16) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    bus(1'b0, 8'h9c, 8'h00, q);
    chk(q, 8'h00);
    bus(1'b0, 8'h9d, 8'h00, q);
    chk(q, 8'h00);
    bus(1'b1, 8'h9e, 8'hff, q);
    bus(1'b0, 8'h9e, 8'h00, q);
    chk(q, 8'h00);
    chk(alias_o, 8'h00);
    bus(1'b0, 8'h9f, 8'h00, q);
    chk(q, 8'h00);
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      m_sel = seed[7:0];
      m_en = seed[15:8];
      bus(1'b1, 8'h9c, m_sel, q);
      bus(1'b1, 8'h9d, m_en, q);
      settle();
      @(negedge sys_clk_in);
      keys = seed[23:16];
      glob = seed[24];
      settle();
      chk(alias_o, m_en);
      chk({7'h0, irq}, {7'h0, |(m_flags & m_en) & glob});
      chk({7'h0, wake}, {7'h0, |(hit() & m_en)});
      bus(1'b0, 8'h9c, 8'h00, q);
      chk(q, m_sel);
      bus(1'b0, 8'h9d, 8'h00, q);
      chk(q, m_en);
      bus(1'b0, 8'h9e, 8'h00, q);
      chk(q, m_flags);
      m_flags = hit();
      bus(1'b0, 8'h9e, 8'h00, q);
      chk(q, m_flags);
      m_flags = hit();
    end
    complete_run();
  end
endmodule : tb_keyboard_level_interrupt
